// ---- design/mcycs_pkg.sv ----
package mcycs_pkg;

  // ----------------------------------------
  // widths and latencies
  // ----------------------------------------
  localparam int DATA_W     = 10;
  localparam int COR_W      = 8;
  localparam int GAIN_W     = 4;
  localparam int ADDR_W     = 4;
  localparam int GAIN_SHIFT = 2;
  localparam int MIX_DLY    = 6;
  localparam int PIPE_LAT   = 10;

  // ----------------------------------------
  // register offsets and field positions
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CORE = 4'h1;
  localparam logic [ADDR_W-1:0] REG_GAIN = 4'h2;
  localparam logic [ADDR_W-1:0] REG_STAT = 4'h3;
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_FORCE_LSB = 2;
  localparam int CORE_C_LSB     = 8;
  localparam int GAIN_C_LSB     = 4;
  localparam int STAT_NS_BIT    = 4;
  localparam int STAT_KILLER_BIT = 5;
  localparam int STAT_ACT_BIT   = 6;
  localparam int STAT_BYP_BIT   = 7;

  // ----------------------------------------
  // tap and flag positions
  // ----------------------------------------
  localparam int TAP_0H   = 0;
  localparam int TAP_1H   = 1;
  localparam int TAP_2H   = 2;
  localparam int TAP_525H = 3;
  localparam int TAP_526H = 4;
  localparam int TAP_527H = 5;
  localparam int FLG_NS   = 0;
  localparam int FLG_LINE = 1;
  localparam int FLG_KILLER       = 2;
  localparam int FLG_FORCE_KILLER = 3;

  // ----------------------------------------
  // modes and reset values
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_SEP      = 2'h0,
    MODE_SEP_PLUS = 2'h1,
    MODE_FRAME_NR = 2'h2,
    MODE_RECUR_NR = 2'h3
  } mcycs_mode_type;

  typedef enum logic [1:0] {
    FORCE_AUTO   = 2'h0,
    FORCE_STOP   = 2'h1,
    FORCE_MOTION = 2'h2
  } mcycs_force_type;

  localparam logic [1:0]        MODE_RST  = MODE_SEP;
  localparam logic [1:0]        FORCE_RST = FORCE_AUTO;
  localparam logic [COR_W-1:0]  CORE_RST  = 8'h04;
  localparam logic [GAIN_W-1:0] GAIN_RST  = 4'h4;
  localparam logic [3:0]        KMAX      = 4'hf;
  localparam logic [4:0]        W_FULL    = 5'h10;

endpackage

// ---- design/mcycs_diff_shaper.sv ----
`timescale 1ns/10ps
// coring, gain and 4-bit limit for one frame difference path
module mcycs_diff_shaper import mcycs_pkg::*; #(
  parameter int DW = DATA_W,
  parameter int CW = COR_W,
  parameter int GW = GAIN_W
) (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          rst_n,
  // difference magnitude and settings
  input  wire logic [DW-1:0] mag,
  input  wire logic [CW-1:0] coring,
  input  wire logic [GW-1:0] gain,
  // limited result
  output logic      [3:0]    lim_out
);

  typedef struct packed {
    logic [3:0] out_r;
  } mcycs_shp_type;

  mcycs_shp_type      st_r;
  mcycs_shp_type      st_nxt;
  logic [DW-1:0]      cored;
  logic [DW+GW-1:0]   prod;
  logic [DW+GW-1:0]   scaled;

  // ----------------------------------------
  // shaping
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    cored = (mag > DW'(coring)) ? mag - DW'(coring) : '0;
    prod   = (DW+GW)'(cored) * (DW+GW)'(gain);
    scaled = prod >> GAIN_SHIFT;
    st_nxt.out_r = (scaled > (DW+GW)'(KMAX)) ? KMAX : scaled[3:0];
  end

  // state register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lim_out = st_r.out_r;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_core_small: assert property (mag <= DW'(coring) |=> lim_out == '0)
    else $error("small difference not cored");
  a_gain_zero: assert property (gain == '0 |=> lim_out == '0)
    else $error("zero gain gave motion");
  a_limit_sat: assert property (scaled > (DW+GW)'(KMAX) |=> lim_out == KMAX)
    else $error("limit not saturated");

endmodule

// ---- design/mcycs_top.sv ----
`timescale 1ns/10ps
// Functional notes
// - one sample per clock at four times subcarrier, 910 per line
// - line comb chroma from current, one-line and two-line taps
// - line comb serves moving and nonstandard parts
// - line comb held at zero in frame noise-reduction mode
// - frame comb from 1-line and 526-line taps; noise in noise mode
// - frame comb used for still regions
// - chroma is motion-weighted blend of line and frame comb
// - nonstandard or force-line input: line comb alone
// - luma is 1-line composite minus chroma or noise
// - killer or force-killer: no subtraction, signal passes through
// - 4-bit motion factor from frame difference drives mixer
// - both frames split by line comb before differencing
// - luma difference low-passed then absolute value
// - chroma magnitudes taken before subtract, then low-pass, magnitude
// - separate coring levels on both difference paths
// - separate gain on each path sets sensitivity
// - each path limited to 4 bits, larger one chosen
// - chosen value widened horizontally before output
// - force select: zero (stop) or maximum (motion)
// - active only in separation and frame noise modes
// - separation mode is mode field 00
module mcycs_top import mcycs_pkg::*; #(
  parameter int DW = DATA_W,
  parameter int CW = COR_W,
  parameter int GW = GAIN_W
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // register port
  input  wire logic [ADDR_W-1:0]    reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  // composite taps from line and frame delays
  input  wire logic [DW-1:0]        comp_0h,
  input  wire logic [DW-1:0]        comp_1h,
  input  wire logic [DW-1:0]        comp_2h,
  input  wire logic [DW-1:0]        comp_525h,
  input  wire logic [DW-1:0]        comp_526h,
  input  wire logic [DW-1:0]        comp_527h,
  // detector results and force pins
  input  wire logic                 nonstandard_detect,
  input  wire logic                 killer_detect,
  input  wire logic                 force_line_comb,
  input  wire logic                 force_killer_input,
  // separated video
  output logic      [DW-1:0]        luma_out,
  output logic signed [DW:0]        chroma_out,
  output logic      [3:0]           motion_factor
);

  localparam int SW = DW + 1;
  localparam int EW = DW + 3;
  localparam int MW = SW + 5;

  typedef struct packed {
    logic [1:0]                      mode_r;
    logic [1:0]                      force_r;
    logic [CW-1:0]                   ycor_r;
    logic [CW-1:0]                   ccor_r;
    logic [GW-1:0]                   ygain_r;
    logic [GW-1:0]                   cgain_r;
    logic [31:0]                     rdata_r;
    logic [5:0][DW-1:0]              tap1_r;
    logic [5:0][DW-1:0]              tap2_r;
    logic [3:0]                      flg1_r;
    logic [3:0]                      flg2_r;
    logic [SW-1:0]                   c2_r;
    logic [SW-1:0]                   c3_r;
    logic [DW-1:0]                   comp_r;
    logic [SW-1:0]                   yfd_r;
    logic [SW-1:0]                   cfd_r;
    logic [1:0][SW-1:0]              dyh_r;
    logic [1:0][SW-1:0]              dch_r;
    logic [DW-1:0]                   ymag_r;
    logic [DW-1:0]                   cmag_r;
    logic [3:0]                      max_r;
    logic [1:0][3:0]                 mh_r;
    logic [3:0]                      k_r;
    logic [MIX_DLY-1:0][SW-1:0]      c2d_r;
    logic [MIX_DLY-1:0][SW-1:0]      c3d_r;
    logic [MIX_DLY-1:0][DW-1:0]      compd_r;
    logic [DW-1:0]                   yout_r;
    logic [SW-1:0]                   cout_r;
  } mcycs_state_type;

  mcycs_state_type        st_r;
  mcycs_state_type        st_nxt;
  logic [3:0]             ysh;
  logic [3:0]             csh;
  logic [DW-1:0]          t0;
  logic [DW-1:0]          t1;
  logic [DW-1:0]          t2;
  logic [DW-1:0]          p0;
  logic [DW-1:0]          p1;
  logic [DW-1:0]          p2;
  logic signed [EW-1:0]   c2w;
  logic signed [EW-1:0]   pc2w;
  logic signed [EW-1:0]   c3w;
  logic signed [SW-1:0]   c2v;
  logic signed [SW-1:0]   pc2v;
  logic signed [SW-1:0]   ca;
  logic signed [SW-1:0]   pca;
  logic [EW-1:0]          ycw;
  logic [EW-1:0]          ypw;
  logic signed [EW-1:0]   ylw;
  logic signed [EW-1:0]   clw;
  logic [3:0]             km;
  logic [4:0]             wl;
  logic [4:0]             wf;
  logic signed [MW-1:0]   mw;
  logic signed [SW-1:0]   mixv;
  logic signed [SW-1:0]   c2o;
  logic signed [SW-1:0]   c3o;
  logic [DW-1:0]          compo;
  logic signed [SW-1:0]   cm;
  logic signed [MW-1:0]   ydiff;
  logic                   act_w;
  logic                   kill_w;
  logic                   byp_w;
  logic [31:0]            stat_w;

  // ----------------------------------------
  // difference shapers
  // ----------------------------------------
  mcycs_diff_shaper #(.DW(DW), .CW(CW), .GW(GW)) u_yshape (
    .clock   (clock),
    .rst_n   (rst_n),
    .mag     (st_r.ymag_r),
    .coring  (st_r.ycor_r),
    .gain    (st_r.ygain_r),
    .lim_out (ysh)
  );

  mcycs_diff_shaper #(.DW(DW), .CW(CW), .GW(GW)) u_cshape (
    .clock   (clock),
    .rst_n   (rst_n),
    .mag     (st_r.cmag_r),
    .coring  (st_r.ccor_r),
    .gain    (st_r.cgain_r),
    .lim_out (csh)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    // register writes
    if (reg_wr) begin
      case (reg_addr)
        REG_CTRL: begin
          st_nxt.mode_r  = reg_wdata[CTRL_MODE_LSB +: 2];
          st_nxt.force_r = reg_wdata[CTRL_FORCE_LSB +: 2];
        end
        REG_CORE: begin
          st_nxt.ycor_r = reg_wdata[0 +: CW];
          st_nxt.ccor_r = reg_wdata[CORE_C_LSB +: CW];
        end
        REG_GAIN: begin
          st_nxt.ygain_r = reg_wdata[0 +: GW];
          st_nxt.cgain_r = reg_wdata[GAIN_C_LSB +: GW];
        end
        default: ;
      endcase
    end
    act_w  = (st_r.mode_r == MODE_SEP) || (st_r.mode_r == MODE_FRAME_NR);
    kill_w = st_r.flg2_r[FLG_KILLER] || st_r.flg2_r[FLG_FORCE_KILLER];
    byp_w = st_r.flg2_r[FLG_NS] || st_r.flg2_r[FLG_LINE];
    // status word
    stat_w = '0;
    stat_w[3:0] = st_r.k_r;
    stat_w[STAT_NS_BIT] = st_r.flg2_r[FLG_NS];
    stat_w[STAT_KILLER_BIT] = kill_w;
    stat_w[STAT_ACT_BIT] = act_w;
    stat_w[STAT_BYP_BIT] = byp_w;
    // read data, valid the cycle after the strobe only
    st_nxt.rdata_r = '0;
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: st_nxt.rdata_r = 32'({st_r.force_r, st_r.mode_r});
        REG_CORE: st_nxt.rdata_r = 32'({st_r.ccor_r, st_r.ycor_r});
        REG_GAIN: st_nxt.rdata_r = 32'({st_r.cgain_r, st_r.ygain_r});
        REG_STAT: st_nxt.rdata_r = stat_w;
        default:  st_nxt.rdata_r = '0;
      endcase
    end
    // two-stage capture of taps, one sample a clock
    st_nxt.tap1_r = {comp_527h, comp_526h, comp_525h, comp_2h, comp_1h, comp_0h};
    st_nxt.tap2_r = st_r.tap1_r;
    st_nxt.flg1_r = {force_killer_input, killer_detect, force_line_comb, nonstandard_detect};
    st_nxt.flg2_r = st_r.flg1_r;
    t0 = st_r.tap2_r[TAP_0H];
    t1 = st_r.tap2_r[TAP_1H];
    t2 = st_r.tap2_r[TAP_2H];
    // previous frame taps around the 526-line sample
    p0 = st_r.tap2_r[TAP_525H];
    p1 = st_r.tap2_r[TAP_526H];
    p2 = st_r.tap2_r[TAP_527H];
    // line comb on 0, 1 and 2 line taps
    c2w  = ($signed({3'b000, t1}) <<< 1) - $signed({3'b000, t0}) - $signed({3'b000, t2});
    pc2w = ($signed({3'b000, p1}) <<< 1) - $signed({3'b000, p0}) - $signed({3'b000, p2});
    c2v  = SW'(c2w >>> 2);
    pc2v = SW'(pc2w >>> 2);
    // line comb zero in frame noise mode
    st_nxt.c2_r = (st_r.mode_r == MODE_FRAME_NR) ? '0 : c2v;
    c3w = $signed({3'b000, t1}) - $signed({3'b000, p1});
    st_nxt.c3_r = SW'(c3w >>> 1);
    st_nxt.comp_r = t1;
    // luma of both frames from line comb
    ycw = ({3'b000, t1} << 1) + EW'(t0) + EW'(t2);
    ypw = ({3'b000, p1} << 1) + EW'(p0) + EW'(p2);
    st_nxt.yfd_r = SW'($signed({3'b000, ycw[EW-1:2]}) - $signed({3'b000, ypw[EW-1:2]}));
    ca  = c2v[SW-1] ? -c2v : c2v;
    pca = pc2v[SW-1] ? -pc2v : pc2v;
    st_nxt.cfd_r = ca - pca;
    st_nxt.dyh_r = {st_r.dyh_r[0], st_r.yfd_r};
    st_nxt.dch_r = {st_r.dch_r[0], st_r.cfd_r};
    ylw = (EW'($signed(st_r.yfd_r)) + (EW'($signed(st_r.dyh_r[0])) <<< 1) + EW'($signed(st_r.dyh_r[1]))) >>> 2;
    st_nxt.ymag_r = ylw[EW-1] ? DW'(-ylw) : DW'(ylw);
    clw = (EW'($signed(st_r.cfd_r)) + (EW'($signed(st_r.dch_r[0])) <<< 1) + EW'($signed(st_r.dch_r[1]))) >>> 2;
    st_nxt.cmag_r = clw[EW-1] ? DW'(-clw) : DW'(clw);
    st_nxt.max_r = (ysh > csh) ? ysh : csh;
    st_nxt.mh_r = {st_r.mh_r[0], st_r.max_r};
    km = st_r.max_r;
    if (st_r.mh_r[0] > km) begin
      km = st_r.mh_r[0];
    end
    if (st_r.mh_r[1] > km) begin
      km = st_r.mh_r[1];
    end
    case (st_r.force_r)
      FORCE_STOP:   st_nxt.k_r = '0;
      FORCE_MOTION: st_nxt.k_r = KMAX;
      default:      st_nxt.k_r = km;
    endcase
    // align comb outputs with motion factor
    st_nxt.c2d_r   = {st_r.c2d_r[MIX_DLY-2:0], st_r.c2_r};
    st_nxt.c3d_r   = {st_r.c3d_r[MIX_DLY-2:0], st_r.c3_r};
    st_nxt.compd_r = {st_r.compd_r[MIX_DLY-2:0], st_r.comp_r};
    c2o   = st_r.c2d_r[MIX_DLY-1];
    c3o   = st_r.c3d_r[MIX_DLY-1];
    compo = st_r.compd_r[MIX_DLY-1];
    // weight 0..16, code max is pure line comb
    wl = {1'b0, st_r.k_r} + {4'b0000, st_r.k_r[3]};
    wf = W_FULL - wl;
    mw = MW'(c3o) * MW'($signed({1'b0, wf})) + MW'(c2o) * MW'($signed({1'b0, wl}));
    mixv = SW'(mw >>> 4);
    cm = byp_w ? c2o : mixv;
    // luma is composite minus chroma or noise
    ydiff = MW'($signed({1'b0, compo})) - MW'(cm);
    // through when idle mode or killer
    if (!act_w || kill_w) begin
      st_nxt.cout_r = '0;
      st_nxt.yout_r = compo;
    end else begin
      st_nxt.cout_r = cm;
      if (ydiff < 0) begin
        st_nxt.yout_r = '0;
      end else if (ydiff > MW'($signed({1'b0, {DW{1'b1}}}))) begin
        st_nxt.yout_r = '1;
      end else begin
        st_nxt.yout_r = DW'(ydiff);
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_r         <= '0;
      st_r.mode_r  <= MODE_RST;
      st_r.force_r <= FORCE_RST;
      st_r.ycor_r  <= CORE_RST;
      st_r.ccor_r  <= CORE_RST;
      st_r.ygain_r <= GAIN_RST;
      st_r.cgain_r <= GAIN_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign reg_rdata     = st_r.rdata_r;
  assign luma_out      = st_r.yout_r;
  assign chroma_out    = st_r.cout_r;
  assign motion_factor = st_r.k_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_stop_held;
    (st_r.force_r == FORCE_STOP) [*2];
  endsequence

  sequence s_motion_held;
    (st_r.force_r == FORCE_MOTION) ##1 (st_r.force_r == FORCE_MOTION);
  endsequence

  a_lcomb_nr_zero: assert property (st_r.mode_r == MODE_FRAME_NR |=> st_r.c2_r == '0)
    else $error("line comb not zero in noise mode");
  a_pipe_latency: assert property (!act_w |=> luma_out == $past(comp_1h, 10) && chroma_out == '0)
    else $error("through path misaligned");
  a_kill_through: assert property (act_w && kill_w |=> chroma_out == '0 && luma_out == $past(compo))
    else $error("killer did not pass through");
  a_line_bypass: assert property (act_w && !kill_w && byp_w |=> chroma_out == $past(c2o))
    else $error("bypass did not use line comb");
  a_frame_still: assert property (act_w && !kill_w && !byp_w && st_r.k_r == '0 |=> chroma_out == $past(c3o))
    else $error("still area not frame comb");
  a_line_motion: assert property (act_w && !kill_w && !byp_w && st_r.k_r == KMAX |=> chroma_out == $past(c2o))
    else $error("full motion not line comb");
  a_force_stop: assert property (s_stop_held |-> motion_factor == '0)
    else $error("forced stop ignored");
  a_force_motion: assert property (s_motion_held |-> motion_factor == KMAX)
    else $error("forced motion ignored");
  a_max_select: assert property (1'b1 |=> st_r.max_r >= $past(ysh) && st_r.max_r >= $past(csh))
    else $error("max selection wrong");

endmodule

// ---- dv/mcycs_video_source.sv ----
`timescale 1ns/10ps
// composite sample stream with line and frame delays built in memory
module mcycs_video_source import mcycs_pkg::*; #(
  parameter int LINE_LEN = 910,
  parameter int LINES    = 525
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // scene settings
  input  wire logic [DATA_W-1:0] luma_level,
  input  wire logic [DATA_W-1:0] frame_step,
  input  wire logic [DATA_W-1:0] chroma_amp,
  // delayed taps
  output logic      [DATA_W-1:0] comp_0h,
  output logic      [DATA_W-1:0] comp_1h,
  output logic      [DATA_W-1:0] comp_2h,
  output logic      [DATA_W-1:0] comp_525h,
  output logic      [DATA_W-1:0] comp_526h,
  output logic      [DATA_W-1:0] comp_527h,
  // raster position
  output int                     line_cnt,
  output int                     pos_cnt
);
  localparam int DEPTH = 528 * LINE_LEN;

  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] y_acc;
  logic              odd_line;
  int                wp;
  int                lin;
  logic [DATA_W-1:0] sample;

  // subcarrier phase flips every line, so 525 lines back it is inverted
  assign sample = odd_line ? y_acc - chroma_amp : y_acc + chroma_amp;

  // read index a number of lines behind the write pointer
  function automatic int back(input int n);
    return (wp + DEPTH - n * LINE_LEN) % DEPTH;
  endfunction

  // delayed sample, zero until that many lines are stored, so no unknowns leak out
  function automatic logic [DATA_W-1:0] tap(input int n);
    return (line_cnt >= n) ? mem[back(n)] : '0;
  endfunction

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wp       <= 0;
      pos_cnt  <= 0;
      line_cnt <= 0;
      lin      <= 0;
      odd_line <= 1'b0;
      y_acc    <= luma_level;
      comp_0h   <= '0;
      comp_1h   <= '0;
      comp_2h   <= '0;
      comp_525h <= '0;
      comp_526h <= '0;
      comp_527h <= '0;
    end else begin
      comp_0h   <= sample;
      mem[wp]   <= sample;
      comp_1h   <= tap(1);
      comp_2h   <= tap(2);
      comp_525h <= tap(525);
      comp_526h <= tap(526);
      comp_527h <= tap(527);
      wp        <= (wp + 1) % DEPTH;
      if (pos_cnt == LINE_LEN - 1) begin
        pos_cnt  <= 0;
        line_cnt <= line_cnt + 1;
        odd_line <= ~odd_line;
        // luma moves by the step once per frame
        if (lin == LINES - 1) begin
          lin   <= 0;
          y_acc <= y_acc + frame_step;
        end else begin
          lin <= lin + 1;
        end
      end else begin
        pos_cnt <= pos_cnt + 1;
      end
    end
  end
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
// directed checks of comb selection, mixing and motion factor
module testbench import mcycs_pkg::*;;
  logic              clock          = 1'b0;
  logic              rst_n          = 1'b0;
  logic [ADDR_W-1:0] reg_addr       = 4'h0;
  logic [31:0]       reg_wdata      = 32'h0;
  logic              reg_wr         = 1'b0;
  logic              reg_rd         = 1'b0;
  logic [3:0]        flags          = 4'h0;
  logic [DATA_W-1:0] frame_step     = 10'h000;
  wire logic [31:0]  reg_rdata;
  wire logic [DATA_W-1:0] comp_0h, comp_1h, comp_2h, comp_525h, comp_526h, comp_527h;
  wire logic [DATA_W-1:0] luma_out;
  wire logic signed [DATA_W:0] chroma_out;
  wire logic [3:0]   motion_factor;
  int                line_cnt;
  int                pos_cnt;
  int                mismatches      = 0;
  int                samples_checked = 0;
  int                cycle_count     = 0;

  // ----------------------------------------
  // clock, parts and watchdog
  // ----------------------------------------
  initial begin
    forever #2.5 clock = ~clock;
  end

  mcycs_video_source #(.LINE_LEN(16), .LINES(525)) u_mcycs_video_source (
    .clock(clock), .rst_n(rst_n), .luma_level(10'h12c), .frame_step(frame_step),
    .chroma_amp(10'h028), .comp_0h(comp_0h), .comp_1h(comp_1h), .comp_2h(comp_2h),
    .comp_525h(comp_525h), .comp_526h(comp_526h), .comp_527h(comp_527h),
    .line_cnt(line_cnt), .pos_cnt(pos_cnt));

  mcycs_top u_mcycs_top (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .comp_0h(comp_0h), .comp_1h(comp_1h), .comp_2h(comp_2h),
    .comp_525h(comp_525h), .comp_526h(comp_526h), .comp_527h(comp_527h),
    .nonstandard_detect(flags[0]), .killer_detect(flags[1]),
    .force_line_comb(flags[2]), .force_killer_input(flags[3]),
    .luma_out(luma_out), .chroma_out(chroma_out), .motion_factor(motion_factor));

  // cut a hang short
  always @(posedge clock) begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == 30000) begin
      mismatches = mismatches + 1;
      close_out();
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic close_out();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic [31:0] mask);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    check("reg_rdata", exp, reg_rdata & mask);
  endtask

  task automatic set_flags(input logic [3:0] v);
    @(posedge clock);
    flags <= v;
  endtask

  // wait for a given line, late in it, where taps are steady
  task automatic at_line(input int n);
    do begin
      @(posedge clock);
      #1;
    end while (!(line_cnt == n && pos_cnt == 14));
  endtask

  // expected outputs from the taps of the current line
  task automatic check_vid(input int w, input bit line_only, input bit nr, input bit kill, input int k);
    int c2;
    int c3;
    int chr;
    int lum;
    c2  = nr ? 0 : (2 * int'(comp_1h) - int'(comp_0h) - int'(comp_2h)) >>> 2;
    c3  = (int'(comp_1h) - int'(comp_526h)) >>> 1;
    chr = kill ? 0 : (line_only ? c2 : (c3 * (16 - w) + c2 * w) >>> 4);
    lum = kill ? int'(comp_1h) : int'(comp_1h) - chr;
    if (lum < 0) lum = 0;
    if (lum > 1023) lum = 1023;
    check("chroma_out", 32'(chr), 32'(chroma_out));
    check("luma_out", 32'(lum), 32'(luma_out));
    if (k >= 0) check("motion_factor", 32'(k), 32'(motion_factor));
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rd_chk(REG_CTRL, 32'h0, 32'hffffffff);
    rd_chk(REG_CORE, 32'h00000404, 32'hffffffff);
    rd_chk(REG_GAIN, 32'h00000044, 32'hffffffff);
    wr(4'h7, 32'hffffffff);
    wr(REG_STAT, 32'hffffffff);
    wr(REG_CTRL, 32'hfffffff0);
    rd_chk(REG_CTRL, 32'h0, 32'hffffffff);
    rd_chk(4'h7, 32'h0, 32'hffffffff);
    // still picture: motion zero, frame comb chosen
    at_line(625);
    check_vid(0, 0, 0, 0, 0);
    rd_chk(REG_STAT, 32'h00000040, 32'h0000007f);
    @(posedge clock);
    frame_step <= 10'h014;
    // moving picture: luma steps 20 per frame
    at_line(1060);
    check_vid(16, 0, 0, 0, 15);
    rd_chk(REG_STAT, 32'h0000004f, 32'h0000007f);
    wr(REG_CTRL, 32'h4);
    at_line(1070);
    check_vid(0, 0, 0, 0, 0);
    wr(REG_CTRL, 32'h8);
    at_line(1080);
    check_vid(16, 0, 0, 0, 15);
    wr(REG_CTRL, 32'h0);
    wr(REG_GAIN, 32'h41);
    at_line(1090);
    check_vid(4, 0, 0, 0, 4);
    wr(REG_CORE, 32'h040c);
    wr(REG_GAIN, 32'h44);
    at_line(1100);
    check_vid(9, 0, 0, 0, 8);
    wr(REG_CORE, 32'h0404);
    wr(REG_CTRL, 32'h4);
    set_flags(4'h1);
    at_line(1110);
    check_vid(0, 1, 0, 0, 0);
    rd_chk(REG_STAT, 32'h00000050, 32'h0000007f);
    set_flags(4'h4);
    at_line(1120);
    check_vid(0, 1, 0, 0, 0);
    set_flags(4'h2);
    at_line(1130);
    check_vid(0, 0, 0, 1, 0);
    set_flags(4'h8);
    at_line(1140);
    check_vid(0, 0, 0, 1, 0);
    set_flags(4'h0);
    wr(REG_CTRL, 32'h6);
    at_line(1150);
    check_vid(0, 0, 1, 0, 0);
    wr(REG_CTRL, 32'h2);
    at_line(1160);
    check_vid(16, 0, 1, 0, 15);
    wr(REG_CTRL, 32'h1);
    at_line(1170);
    check_vid(0, 0, 0, 1, -1);
    wr(REG_CTRL, 32'h3);
    at_line(1180);
    check_vid(0, 0, 0, 1, -1);
    close_out();
  end
endmodule
